// ---- rtl/rs485_pkg.sv ----
/*
 * rs485_pkg: register offsets, field positions, reset values, timing constants
 * and the packed structs shared by the RS-485 multidrop serial port.
 * Assumes a 32-bit APB slave clocked by pclk at 200 MHz.
 */
`default_nettype none

package rs485_pkg;

    localparam logic [7:0]  OFF_DATA        = 8'h00;
    localparam logic [7:0]  OFF_INT_ENABLE  = 8'h04;
    localparam logic [7:0]  OFF_FIFO_CTRL   = 8'h08;
    localparam logic [7:0]  OFF_LINE_CTRL   = 8'h0c;
    localparam logic [7:0]  OFF_MODEM_CTRL  = 8'h10;
    localparam logic [7:0]  OFF_MODEM_STAT  = 8'h14;
    localparam logic [7:0]  OFF_FIFO_STAT   = 8'h18;
    localparam logic [7:0]  OFF_INT_STATUS  = 8'h1c;
    localparam logic [7:0]  OFF_TIMEOUT     = 8'h20;
    localparam logic [7:0]  OFF_BAUD        = 8'h24;
    localparam logic [7:0]  OFF_IR_CTRL     = 8'h28;
    localparam logic [7:0]  OFF_ALT_CTRL    = 8'h2c;
    localparam logic [7:0]  OFF_FUNC_SEL    = 8'h30;

    localparam logic [31:0] RST_MODEM_CTRL  = 32'h0000_0200;
    localparam logic [31:0] RST_MODEM_STAT  = 32'h0000_0110;
    localparam logic [31:0] RST_FIFO_STAT   = 32'h1040_4000;
    localparam logic [31:0] RST_BAUD        = 32'h0F00_0000;
    localparam logic [31:0] RST_IR_CTRL     = 32'h0000_0040;
    localparam logic [31:0] ZERO_WORD       = 32'h0000_0000;

    // fifo_control bits
    localparam int FC_RX_CLEAR              = 1;
    localparam int FC_TX_CLEAR              = 2;
    localparam int FC_RECEIVER_DISABLE      = 8;
    localparam int FC_PRE_ADDR_DISCARD      = 9;
    // line_control bits
    localparam int LC_PARITY_ENABLE         = 3;
    localparam int LC_EVEN_PARITY           = 4;
    localparam int LC_STICK_PARITY          = 5;
    // modem_control bits
    localparam int MC_RTS_SOFT              = 1;
    localparam int MC_RTS_POLARITY          = 9;
    // timeout_control field
    localparam int TO_DELAY_LSB             = 8;
    // alternate_control_status bits
    localparam int AC_NORMAL_MULTIDROP      = 8;
    localparam int AC_AUTO_ADDRESS          = 9;
    localparam int AC_AUTO_DIRECTION        = 10;
    localparam int AC_MATCH_LSB             = 24;
    // function_select codes
    localparam logic [1:0]  FUNC_RS485      = 2'h3;
    // interrupt status / enable bits
    localparam int IS_RX_AVAIL              = 0;
    localparam int IS_TX_EMPTY              = 1;
    localparam int IS_ADDRESS               = 2;
    localparam int IS_BUF_ERR               = 5;

    localparam int FIFO_DEPTH               = 16;
    localparam int PTR_W                    = 4;
    localparam logic [4:0]  FIFO_FULL_COUNT = 5'h10;
    localparam logic [3:0]  BIT_COUNT       = 4'hA;
    localparam logic [3:0]  OVERSAMPLE_LAST = 4'hF;
    localparam logic [3:0]  OVERSAMPLE_MID  = 4'h7;
    localparam logic [15:0] BAUD_ONE        = 16'h0001;

    typedef struct packed {
        logic [8:0] shift;
        logic [3:0] bits;
        logic [3:0] tick;
        logic       busy;
    } rx_state_t;

    typedef struct packed {
        logic [10:0] shift;
        logic [3:0]  bits;
        logic [3:0]  tick;
        logic        busy;
    } tx_state_t;

    typedef struct packed {
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
    } apb_resp_t;

endpackage

`default_nettype wire

// ---- rtl/rs485_uart.sv ----
/*
 * rs485_uart: APB register file, 9-bit receiver with multidrop / address-match
 * filter, 9-bit transmitter with stick parity, and automatic driver enable.
 * Assumes rxd is synchronous to pclk; baud tick = pclk / (divisor+1), sixteen ticks per bit.
 */
`default_nettype none

module rs485_uart
    import rs485_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        rxd,
    output logic             txd,
    output logic             rts,
    output logic             irq
);

    ////////////////////////////////////////////////////////////////////////////
    typedef struct packed {
        logic [31:0]       int_enable;
        logic [31:0]       fifo_ctrl;
        logic [31:0]       line_ctrl;
        logic [31:0]       modem_ctrl;
        logic [31:0]       timeout;
        logic [31:0]       baud;
        logic [31:0]       ir_ctrl;
        logic [31:0]       alt_ctrl;
        logic [31:0]       func_sel;
        logic [5:0]        int_status;
        apb_resp_t         resp;
        logic [15:0]       baud_cnt;
        rx_state_t         rx;
        tx_state_t         tx;
        logic [PTR_W-1:0]  rx_wr;
        logic [PTR_W-1:0]  rx_rd;
        logic [4:0]        rx_count;
        logic [PTR_W-1:0]  tx_wr;
        logic [PTR_W-1:0]  tx_rd;
        logic [4:0]        tx_count;
        logic              addr_matched;
        logic [7:0]        turn_cnt;
        logic [3:0]        turn_tick;
        logic              drive_en;
        logic              txd;
        logic              rts;
        logic              irq;
    } state_t;

    state_t     s_reg;
    state_t     s_next;
    logic [7:0] rx_mem_reg [FIFO_DEPTH];
    logic [8:0] tx_mem_reg [FIFO_DEPTH];

    logic       setup;
    logic       access_wr;
    logic       tick;
    logic       rx_done;
    logic [8:0] rx_char;
    logic       is_addr;
    logic       store;
    logic       rx_push;
    logic       rx_pop;
    logic       tx_push;
    logic       tx_pop;
    logic       tx_bit9;
    logic       rs485_on;
    logic       auto_dir;
    logic       rts_active;
    logic [5:0] events;

    ////////////////////////////////////////////////////////////////////////////
    // combinational next state
    always_comb begin
        s_next      = s_reg;
        setup       = psel && !penable;
        access_wr   = psel && penable && pwrite;
        tick        = (s_reg.baud_cnt == s_reg.baud[15:0]);
        rx_done     = 1'b0;
        rx_char     = s_reg.rx.shift;
        store       = 1'b0;
        rx_push     = 1'b0;
        rx_pop      = 1'b0;
        tx_push     = 1'b0;
        tx_pop      = 1'b0;
        events      = '0;
        rs485_on    = (s_reg.func_sel[1:0] == FUNC_RS485);
        auto_dir    = rs485_on && s_reg.alt_ctrl[AC_AUTO_DIRECTION];
        is_addr     = rx_char[8];
        // stick parity: even set sends 0, even clear sends 1
        tx_bit9     = s_reg.line_ctrl[LC_PARITY_ENABLE] && s_reg.line_ctrl[LC_STICK_PARITY]
                      && !s_reg.line_ctrl[LC_EVEN_PARITY];

        s_next.baud_cnt = tick ? 16'h0000 : s_reg.baud_cnt + BAUD_ONE;

        // receiver: start, eight data bits LSB first, ninth bit, stop
        if (tick) begin
            if (!s_reg.rx.busy) begin
                if (!rxd) begin
                    s_next.rx.busy = 1'b1;
                    s_next.rx.tick = 4'h0;
                    s_next.rx.bits = 4'h0;
                end
            end else begin
                s_next.rx.tick = s_reg.rx.tick + 4'h1;
                if (s_reg.rx.tick == OVERSAMPLE_MID) begin
                    if (s_reg.rx.bits == 4'h0 && rxd) begin
                        s_next.rx.busy = 1'b0;
                    end else if (s_reg.rx.bits == BIT_COUNT) begin
                        // done at mid stop, so the ninth bit is already shifted in
                        s_next.rx.busy = 1'b0;
                        rx_done        = 1'b1;
                    end else begin
                        if (s_reg.rx.bits != 4'h0) begin
                            s_next.rx.shift = {rxd, s_reg.rx.shift[8:1]};
                        end
                    end
                    s_next.rx.bits = s_reg.rx.bits + 4'h1;
                end
            end
        end

        // receive filter
        if (rx_done) begin
            if (!rs485_on) begin
                store = 1'b1;
            end else if (s_reg.alt_ctrl[AC_AUTO_ADDRESS]) begin
                if (is_addr) begin
                    s_next.addr_matched = (rx_char[7:0] == s_reg.alt_ctrl[AC_MATCH_LSB +: 8]);
                    store = s_next.addr_matched;
                end else begin
                    store = s_reg.addr_matched;
                end
            end else if (s_reg.alt_ctrl[AC_NORMAL_MULTIDROP]) begin
                if (is_addr) begin
                    store                = 1'b1;
                    s_next.addr_matched  = 1'b1;
                    events[IS_ADDRESS]   = 1'b1;
                end else if (s_reg.fifo_ctrl[FC_RECEIVER_DISABLE]) begin
                    store = 1'b0;
                end else if (s_reg.fifo_ctrl[FC_PRE_ADDR_DISCARD]) begin
                    store = s_reg.addr_matched;
                end else begin
                    store = 1'b1;
                end
            end else begin
                store = 1'b1;
            end
        end
        if (store && s_reg.rx_count == FIFO_FULL_COUNT) begin
            events[IS_BUF_ERR] = 1'b1;
        end
        rx_push = store && (s_reg.rx_count != FIFO_FULL_COUNT);

        // apb access, no wait state: pready rises the cycle after setup
        s_next.resp.pready  = setup;
        s_next.resp.pslverr = 1'b0;
        if (setup && !pwrite) begin
            unique case (paddr)
                OFF_DATA: begin
                    s_next.resp.prdata = {24'h00_0000, rx_mem_reg[s_reg.rx_rd]};
                    rx_pop             = (s_reg.rx_count != 5'h00);
                end
                OFF_INT_ENABLE: s_next.resp.prdata = s_reg.int_enable;
                OFF_FIFO_CTRL:  s_next.resp.prdata = s_reg.fifo_ctrl;
                OFF_LINE_CTRL:  s_next.resp.prdata = s_reg.line_ctrl;
                OFF_MODEM_CTRL: s_next.resp.prdata = s_reg.modem_ctrl;
                OFF_MODEM_STAT: s_next.resp.prdata = RST_MODEM_STAT;
                // empty flags at bits 22 and 14 give the reset word
                OFF_FIFO_STAT:  s_next.resp.prdata = {RST_FIFO_STAT[31:24], 1'b0,
                                    (s_reg.tx_count == 5'h00), 1'b0, s_reg.tx_count, 1'b0,
                                    (s_reg.rx_count == 5'h00), 1'b0, s_reg.rx_count, 8'h00};
                OFF_INT_STATUS: begin
                    s_next.resp.prdata = {26'h0, s_reg.int_status};
                    s_next.int_status  = '0;
                end
                OFF_TIMEOUT:    s_next.resp.prdata = s_reg.timeout;
                OFF_BAUD:       s_next.resp.prdata = s_reg.baud;
                OFF_IR_CTRL:    s_next.resp.prdata = s_reg.ir_ctrl;
                OFF_ALT_CTRL:   s_next.resp.prdata = s_reg.alt_ctrl;
                OFF_FUNC_SEL:   s_next.resp.prdata = s_reg.func_sel;
                default: begin
                    s_next.resp.prdata  = ZERO_WORD;
                    s_next.resp.pslverr = 1'b1;
                end
            endcase
        end else if (setup) begin
            s_next.resp.prdata = ZERO_WORD;
            unique case (paddr)
                OFF_DATA, OFF_INT_ENABLE, OFF_FIFO_CTRL, OFF_LINE_CTRL, OFF_MODEM_CTRL,
                OFF_MODEM_STAT, OFF_FIFO_STAT, OFF_INT_STATUS, OFF_TIMEOUT, OFF_BAUD,
                OFF_IR_CTRL, OFF_ALT_CTRL, OFF_FUNC_SEL: s_next.resp.pslverr = 1'b0;
                default: s_next.resp.pslverr = 1'b1;
            endcase
        end
        if (access_wr && s_reg.resp.pready) begin
            unique case (paddr)
                OFF_DATA:       tx_push = (s_reg.tx_count != FIFO_FULL_COUNT);
                OFF_INT_ENABLE: s_next.int_enable = pwdata;
                OFF_FIFO_CTRL:  s_next.fifo_ctrl  = pwdata;
                OFF_LINE_CTRL:  s_next.line_ctrl  = pwdata;
                OFF_MODEM_CTRL: s_next.modem_ctrl = pwdata;
                OFF_TIMEOUT:    s_next.timeout    = pwdata;
                OFF_BAUD:       s_next.baud       = pwdata;
                OFF_IR_CTRL:    s_next.ir_ctrl    = pwdata;
                OFF_ALT_CTRL: begin
                    s_next.alt_ctrl     = pwdata;
                    s_next.addr_matched = 1'b0;
                end
                OFF_FUNC_SEL:   s_next.func_sel   = pwdata;
                default:        s_next.func_sel   = s_reg.func_sel;
            endcase
        end

        // transmitter: start, 8 data, ninth bit, stop
        if (!s_reg.tx.busy) begin
            s_next.txd = 1'b1;
            if (s_reg.tx_count != 5'h00 && tick && (!auto_dir || s_reg.drive_en)) begin
                tx_pop          = 1'b1;
                s_next.tx.busy  = 1'b1;
                s_next.tx.shift = {1'b1, tx_mem_reg[s_reg.tx_rd], 1'b0};
                s_next.tx.bits  = 4'h0;
                s_next.tx.tick  = 4'h0;
            end
        end else if (tick) begin
            s_next.txd     = s_reg.tx.shift[0];
            s_next.tx.tick = s_reg.tx.tick + 4'h1;
            if (s_reg.tx.tick == OVERSAMPLE_LAST) begin
                s_next.tx.shift = {1'b1, s_reg.tx.shift[10:1]};
                s_next.tx.bits  = s_reg.tx.bits + 4'h1;
                if (s_reg.tx.bits == BIT_COUNT) begin
                    s_next.tx.busy = 1'b0;
                    events[IS_TX_EMPTY] = (s_reg.tx_count == 5'h00);
                end
            end
        end

        // driver enable: up while data queued, then held for the turnaround delay
        if (s_reg.tx_count != 5'h00 || s_reg.tx.busy || tx_push) begin
            s_next.drive_en  = 1'b1;
            s_next.turn_cnt  = s_reg.timeout[TO_DELAY_LSB +: 8];
            s_next.turn_tick = 4'h0;
        end else if (s_reg.turn_cnt != 8'h00) begin
            if (tick) begin
                s_next.turn_tick = s_reg.turn_tick + 4'h1;
                if (s_reg.turn_tick == OVERSAMPLE_LAST) begin
                    s_next.turn_cnt = s_reg.turn_cnt - 8'h01;
                end
            end
        end else begin
            s_next.drive_en = 1'b0;
        end
        // polarity bit clear inverts the active level
        rts_active  = auto_dir ? s_reg.drive_en : s_reg.modem_ctrl[MC_RTS_SOFT];
        s_next.rts  = s_reg.modem_ctrl[MC_RTS_POLARITY] ? rts_active : !rts_active;

        // fifo pointers; clear controls self-clear
        if (rx_push) begin
            s_next.rx_wr = s_reg.rx_wr + 4'h1;
        end
        if (rx_pop) begin
            s_next.rx_rd = s_reg.rx_rd + 4'h1;
        end
        s_next.rx_count = s_reg.rx_count + {4'h0, rx_push} - {4'h0, rx_pop};
        if (tx_push) begin
            s_next.tx_wr = s_reg.tx_wr + 4'h1;
        end
        if (tx_pop) begin
            s_next.tx_rd = s_reg.tx_rd + 4'h1;
        end
        s_next.tx_count = s_reg.tx_count + {4'h0, tx_push} - {4'h0, tx_pop};
        if (s_reg.fifo_ctrl[FC_RX_CLEAR]) begin
            s_next.rx_rd                  = s_reg.rx_wr;
            s_next.rx_count               = 5'h00;
            s_next.fifo_ctrl[FC_RX_CLEAR] = 1'b0;
        end
        if (s_reg.fifo_ctrl[FC_TX_CLEAR]) begin
            s_next.tx_rd                  = s_reg.tx_wr;
            s_next.tx_count               = 5'h00;
            s_next.fifo_ctrl[FC_TX_CLEAR] = 1'b0;
        end

        // sticky status: set wins over the read clear
        events[IS_RX_AVAIL] = rx_push;
        s_next.int_status   = s_next.int_status | events;
        s_next.irq          = |(s_next.int_status & s_reg.int_enable[5:0]);
        s_next.txd          = s_next.txd;
    end

    ////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_reg            <= '0;
            s_reg.modem_ctrl <= RST_MODEM_CTRL;
            s_reg.baud       <= RST_BAUD;
            s_reg.ir_ctrl    <= RST_IR_CTRL;
            s_reg.int_status <= 6'h02;
            s_reg.txd        <= 1'b1;
        end else begin
            s_reg <= s_next;
        end
    end

    // storage arrays, no reset needed
    always_ff @(posedge pclk) begin
        if (rx_push) begin
            rx_mem_reg[s_reg.rx_wr] <= rx_char[7:0];
        end
        if (tx_push) begin
            tx_mem_reg[s_reg.tx_wr] <= {tx_bit9, pwdata[7:0]};
        end
    end

    assign prdata  = s_reg.resp.prdata;
    assign pready  = s_reg.resp.pready;
    assign pslverr = s_reg.resp.pslverr;
    assign txd     = s_reg.txd;
    assign rts     = s_reg.rts;
    assign irq     = s_reg.irq;

endmodule

`default_nettype wire

// ---- tb/rs485_node_model.sv ----
/* node model: far bus node that frames 9-bit characters onto rxd and
   decodes txd frames with the driver enable seen at the start bit. */
`default_nettype none
module rs485_node_model (
    input  wire logic       pclk,
    input  wire logic       txd,
    input  wire logic       rts,
    output logic            rxd,
    output logic [8:0]      cap,
    output logic            cap_rts,
    output int              cap_cnt
);
    timeunit 1ns;
    timeprecision 1ps;
    ////////////////////////////////////////////////////////////////////////////////
    task automatic send(input logic [8:0] c);
        logic [10:0] f;
        f = {1'b1, c, 1'b0};
        for (int i = 0; i < 11; i++) begin
            @(posedge pclk);
            rxd <= f[i];
            repeat (15) @(posedge pclk);
        end
    endtask
    // line failsafe bias keeps rxd idle high between frames
    initial begin
        rxd = 1'b1;
        cap = 9'h000;
        cap_rts = 1'b0;
        cap_cnt = 0;
        forever begin
            @(negedge txd);
            repeat (8) @(posedge pclk);
            cap_rts = rts;
            for (int i = 0; i < 9; i++) begin
                repeat (16) @(posedge pclk);
                cap[i] = txd;
            end
            repeat (16) @(posedge pclk);
            if (txd) begin
                cap_cnt++;
            end
        end
    end
endmodule
`default_nettype wire

// ---- tb/rs485_uart_properties.sv ----
/* checker: apb handshake and serial frame relations on the top ports.
   assumes baud divisor zero, so one bit lasts sixteen pclk cycles. */
`default_nettype none
module rs485_uart_properties (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        rxd,
    input wire logic        txd,
    input wire logic        rts,
    input wire logic        irq
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    ////////////////////////////////////////////////////////////////////////////////
    chk_ready_setup: assert property (psel && !penable |=> pready)
        else $error("no ready after setup");
    chk_ready_single: assert property (pready |=> !pready)
        else $error("ready held too long");
    chk_ready_access: assert property (pready |-> psel && penable)
        else $error("ready outside access");
    chk_err_unmapped: assert property (psel && !penable && paddr > 8'h30 |=>
        pslverr && prdata == 32'h0000_0000) else $error("unmapped not refused");
    chk_err_mapped: assert property (psel && !penable && paddr <= 8'h30 &&
        paddr[1:0] == 2'b00 |=> !pslverr) else $error("mapped offset refused");
    chk_rx_upper: assert property (pready && !pwrite && paddr == 8'h00 |->
        prdata[31:8] == 24'h00_0000) else $error("upper data bits set");
    chk_start_width: assert property ($fell(txd) |-> (!txd) [*8])
        else $error("start bit too short");
    chk_stop_level: assert property ($fell(txd) |-> ##170 txd)
        else $error("stop bit missing");
    cover property (pready && pslverr);
    cover property ($fell(txd));
    cover property ($rose(irq));
endmodule

bind rs485_uart rs485_uart_properties u_rs485_uart_properties (.pclk, .presetn, .psel,
    .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .rxd, .txd, .rts, .irq);
`default_nettype wire

// ---- tb/uart_rs485_multidrop_bench.sv ----
/* bench: register resets, multidrop and address-match filtering, transmit
   with automatic driver enable. assumes baud divisor zero after reset. */
`default_nettype none
module uart_rs485_multidrop_bench
    import rs485_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic        pclk;
    logic        presetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        rxd;
    logic        txd;
    logic        rts;
    logic        irq;
    logic [8:0]  cap;
    logic        cap_rts;
    int          cap_cnt;
    int          num_errors = 0;
    int          num_checks = 0;
    int          seed = 32'h25fc_e7f3;
    int          n;
    logic [31:0] rd;
    logic        er;
    logic [7:0]  d;
    logic [7:0]  m;
    localparam logic [7:0]  RA [12] = '{OFF_INT_ENABLE, OFF_FIFO_CTRL, OFF_LINE_CTRL,
        OFF_MODEM_CTRL, OFF_MODEM_STAT, OFF_FIFO_STAT, OFF_INT_STATUS, OFF_TIMEOUT,
        OFF_BAUD, OFF_IR_CTRL, OFF_ALT_CTRL, OFF_FUNC_SEL};
    localparam logic [31:0] RV [12] = '{ZERO_WORD, ZERO_WORD, ZERO_WORD, RST_MODEM_CTRL,
        RST_MODEM_STAT, RST_FIFO_STAT, 32'h0000_0002, ZERO_WORD, RST_BAUD, RST_IR_CTRL,
        ZERO_WORD, ZERO_WORD};
    rs485_uart u_rs485_uart (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .rxd, .txd, .rts, .irq);
    rs485_node_model u_rs485_node_model (.pclk, .txd, .rts, .rxd, .cap, .cap_rts, .cap_cnt);
    always #2.5 pclk = ~pclk;
    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [7:0] rnd();
        return 8'($random(seed));
    endfunction
    function automatic logic ninth(input logic even);
        return !even;
    endfunction
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] wd);
        apb(1'b1, a, wd);
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, ZERO_WORD);
        chk(rd, exp);
    endtask
    task automatic empty_chk();
        apb(1'b0, OFF_FIFO_STAT, ZERO_WORD);
        chk(rd & 32'h0000_1f00, ZERO_WORD);
    endtask
    task automatic send(input logic [8:0] c);
        u_rs485_node_model.send(c);
    endtask
    task automatic end_of_test();
        if (num_errors == 0 && num_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (40000) @(posedge pclk);
        num_errors++;
        end_of_test();
    end
    initial begin
        pclk = 1'b0;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = ZERO_WORD;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        for (int i = 0; i < 12; i++) begin
            rdchk(RA[i], RV[i]);
        end
        apb(1'b0, 8'h34, ZERO_WORD);
        chk({rd[31:1], er}, 32'h0000_0001);
        wr(OFF_FUNC_SEL, {30'h0, FUNC_RS485});
        wr(OFF_FIFO_CTRL, ZERO_WORD);
        wr(OFF_ALT_CTRL, 32'h0000_0100);
        wr(OFF_INT_ENABLE, 32'h0000_0004);
        d = rnd();
        m = rnd();
        send({1'b0, d});
        send({1'b1, m});
        chk({31'h0, irq}, 32'h0000_0001);
        rdchk(OFF_DATA, {24'h00_0000, d});
        rdchk(OFF_DATA, {24'h00_0000, m});
        apb(1'b0, OFF_INT_STATUS, ZERO_WORD);
        chk(rd & 32'h0000_0004, 32'h0000_0004);
        repeat (2) @(posedge pclk);
        chk({31'h0, irq}, ZERO_WORD);
        wr(OFF_INT_ENABLE, ZERO_WORD);
        wr(OFF_FIFO_CTRL, 32'h0000_0200);
        wr(OFF_ALT_CTRL, 32'h0000_0100);
        send({1'b0, rnd()});
        send({1'b1, m});
        d = rnd();
        send({1'b0, d});
        chk({31'h0, irq}, ZERO_WORD);
        wr(OFF_INT_ENABLE, 32'h0000_0004);
        repeat (2) @(posedge pclk);
        chk({31'h0, irq}, 32'h0000_0001);
        rdchk(OFF_DATA, {24'h00_0000, m});
        rdchk(OFF_DATA, {24'h00_0000, d});
        empty_chk();
        apb(1'b0, OFF_INT_STATUS, ZERO_WORD);
        wr(OFF_FIFO_CTRL, 32'h0000_0300);
        send({1'b0, rnd()});
        m = rnd();
        send({1'b1, m});
        send({1'b0, rnd()});
        rdchk(OFF_DATA, {24'h00_0000, m});
        empty_chk();
        m = rnd();
        d = rnd();
        wr(OFF_FIFO_CTRL, ZERO_WORD);
        wr(OFF_ALT_CTRL, {m, 24'h00_0200});
        send({1'b0, m});
        send({1'b1, m ^ 8'h01});
        send({1'b1, m});
        send({1'b0, d});
        send({1'b1, m ^ 8'h80});
        send({1'b0, d});
        rdchk(OFF_DATA, {24'h00_0000, m});
        rdchk(OFF_DATA, {24'h00_0000, d});
        empty_chk();
        wr(OFF_ALT_CTRL, 32'h0000_0400);
        wr(OFF_TIMEOUT, 32'h0000_0200);
        for (int e = 0; e < 2; e++) begin
            d = rnd();
            n = cap_cnt;
            wr(OFF_LINE_CTRL, e[0] ? 32'h0000_0038 : 32'h0000_0028);
            wr(OFF_DATA, {24'h00_0000, d});
            while (cap_cnt == n) @(posedge pclk);
            chk({23'h0, cap}, {23'h0, ninth(e[0]), d});
            chk({31'h0, cap_rts}, 32'h0000_0001);
            repeat (24) @(posedge pclk);
            chk({31'h0, rts}, 32'h0000_0001);
            repeat (80) @(posedge pclk);
            chk({31'h0, rts}, ZERO_WORD);
        end
        wr(OFF_MODEM_CTRL, ZERO_WORD);
        repeat (2) @(posedge pclk);
        chk({31'h0, rts}, 32'h0000_0001);
        end_of_test();
    end
endmodule
`default_nettype wire
